// file: include/pfs_defines.svh
// Purpose: offsets, field positions and reset values of the status bytes
// Assumes: included by its bare name
// Notes:   definitions only
`ifndef PFS_DEFINES_SVH
`define PFS_DEFINES_SVH
`define PFS_CODE_VOUT_STATUS   8'h7a
`define PFS_CODE_IOUT_STATUS   8'h7b
`define PFS_CODE_INPUT_STATUS  8'h7c
`define PFS_CODE_VENDOR_STATUS 8'h80
`define PFS_STATUS_RESET       8'h00
`define PFS_VOUT_OV_BIT        6
`define PFS_VOUT_UV_BIT        5
`define PFS_OVERCURRENT_TIMEOUT_FAULT_BIT  7
`define PFS_OVERCURRENT_WARNING_BIT   5
`define PFS_IN_OV_FAULT_BIT    7
`define PFS_IN_OV_WARN_BIT     6
`define PFS_IN_UV_WARN_BIT     5
`define PFS_IN_UV_FAULT_BIT    4
`define PFS_IN_OP_WARN_BIT     0
`define PFS_VS_FET_BIT         7
`define PFS_VS_UV_LIVE_BIT     6
`define PFS_VS_OV_LIVE_BIT     5
`define PFS_VS_LIMIT_BIT       3
`define PFS_VS_CAUSE_HI        2
`define PFS_VS_CAUSE_LO        1
`define PFS_VS_WARN2_BIT       0
`define PFS_SUM_VOUT_BIT       15
`define PFS_SUM_IOUT_BIT       14
`define PFS_SUM_INPUT_BIT      13
`define PFS_SUM_VENDOR_BIT     12
`endif

// file: include/pfs_pkg.sv
// Purpose: types shared by the status byte block
// Assumes: nothing
// Notes:   shutdown reason encoding follows the vendor byte field
package pfs_pkg;
  typedef enum logic [1:0] {
    PFS_CAUSE_NONE = 2'h0,
    PFS_CAUSE_OC   = 2'h1,
    PFS_CAUSE_UV   = 2'h2,
    PFS_CAUSE_OV   = 2'h3
  } pfs_cause_t;
endpackage

// file: core/pfs_sync.sv
// Purpose: two flip-flop synchroniser for a vector of async inputs
// Assumes: inputs are levels held much longer than a core_clk period
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module pfs_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_reg;

  // plain double register, constant on reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_reg <= '0;
      sync_out   <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end
endmodule

// file: core/pfs_status_bytes.sv
// Purpose: four read-byte fault and warning status registers
// Assumes: event inputs are async levels; read_code is same-domain
// Notes:   latched bits cleared only by clear_faults or reset
//          live comparator bits bypass the latches entirely
//          an input change shows in its byte three edges later, the live bits two
//
// Functional notes
// - code 7a returns output voltage byte
// - latch output over/undervoltage at bits 6,5
// - code 7b returns output current byte
// - timeout fault only after timer and shutdown
// - latch overcurrent warning at bit 5
// - code 7c returns input byte, bits 3:1 zero
// - latch pin overvoltage bit 7, undervoltage bit 4
// - latch monitor input warnings at bits 6,5
// - latch input overpower warning at bit 0
// - code 80 returns vendor byte, bit4 zero
// - latch suspected pass-transistor short at bit 7
// - live comparator states at bits 6,5
// - latch current limiting immediately at bit 3
// - latch shutdown reason in bits 2:1
// - latch second warning, polarity selectable
// - summary bits flag nonzero status bytes
`timescale 1ns/1ps
`include "pfs_defines.svh"
module pfs_status_bytes (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        output_overvoltage_warning,
  input  wire logic        output_undervoltage_warning,
  input  wire logic        overcurrent_timer_expired,
  input  wire logic        gate_shut_down,
  input  wire logic        overcurrent_warning,
  input  wire logic        undervoltage_comparator_live,
  input  wire logic        overvoltage_comparator_live,
  input  wire logic        input_overvoltage_warning,
  input  wire logic        input_undervoltage_warning,
  input  wire logic        input_overpower_warning,
  input  wire logic        pass_transistor_suspect_short,
  input  wire logic        current_limiting_active,
  input  wire logic        second_current_over,
  input  wire logic        second_current_under,
  input  wire logic        second_warning_polarity_select,
  input  wire logic        clear_faults,
  input  wire logic        read_strobe,
  input  wire logic [7:0]  read_code,
  output logic      [7:0]  read_data,
  output logic             read_valid,
  output logic             read_unsupported,
  output logic      [3:0]  status_summary
);
  localparam int NSYNC = 13;

  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] syn;
  logic             ov_out_s, uv_out_s, oc_tmo_s, gate_off_s, oc_warn_s;
  logic             uv_live_s, ov_live_s, in_ov_w_s, in_uv_w_s, op_w_s;
  logic             fet_s, lim_s, warn2_s;
  logic             w2_over_s, w2_under_s, w2_sel_s;

  // latched status bits
  logic             vout_ov_reg, vout_uv_reg;
  logic             oc_fault_reg, oc_warn_reg;
  logic             in_ov_fault_reg, in_ov_warn_reg;
  logic             in_uv_warn_reg, in_uv_fault_reg, in_op_warn_reg;
  logic             fet_reg, limit_reg, warn2_reg;
  pfs_pkg::pfs_cause_t cause_reg, cause_next;
  logic             gate_off_d_reg;
  logic             oc_fault_set;
  logic [7:0]       vout_byte, iout_byte, input_byte, vendor_byte;
  logic [7:0]       read_data_next;
  logic             code_hit;
  logic             vout_ov_next, vout_uv_next;
  logic             oc_fault_next, oc_warn_next;
  logic             in_ov_fault_next, in_ov_warn_next;
  logic             in_uv_warn_next, in_uv_fault_next, in_op_warn_next;
  logic             fet_next, limit_next, warn2_next;
  logic             gate_off_rise;
  logic             hit_vout, hit_iout, hit_input, hit_vendor;
  logic [3:0]       summary_next;

  // all event inputs arrive from analog or other-domain logic
  assign raw_in = {output_overvoltage_warning, output_undervoltage_warning,
                   overcurrent_timer_expired, gate_shut_down,
                   overcurrent_warning, undervoltage_comparator_live,
                   overvoltage_comparator_live, input_overvoltage_warning,
                   input_undervoltage_warning, input_overpower_warning,
                   pass_transistor_suspect_short, current_limiting_active,
                   second_current_over};

  pfs_sync #(.WIDTH(NSYNC)) u_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .async_in (raw_in),
    .sync_out (syn)
  );

  // under-threshold and select pass a second synchroniser
  pfs_sync #(.WIDTH(2)) u_sync_w2 (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .async_in ({second_current_under, second_warning_polarity_select}),
    .sync_out ({w2_under_s, w2_sel_s})
  );

  // name the synchronised levels
  assign {ov_out_s, uv_out_s, oc_tmo_s, gate_off_s, oc_warn_s,
          uv_live_s, ov_live_s, in_ov_w_s, in_uv_w_s, op_w_s,
          fet_s, lim_s, w2_over_s} = syn;

  // polarity select picks under (1) or over (0) crossing
  assign warn2_s = w2_sel_s ? w2_under_s : w2_over_s;

  // fault needs both the timer lapse and the gate pulled down
  assign oc_fault_set = oc_tmo_s && gate_off_s;

  // output voltage byte: monitor warnings, an event beats a clear
  assign vout_ov_next = ov_out_s | (vout_ov_reg & ~clear_faults);
  assign vout_uv_next = uv_out_s | (vout_uv_reg & ~clear_faults);

  // output voltage flags
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      vout_ov_reg <= 1'b0;
      vout_uv_reg <= 1'b0;
    end else begin
      vout_ov_reg <= vout_ov_next;
      vout_uv_reg <= vout_uv_next;
    end
  end

  // output current byte: the fault waits for the timed-out shutdown,
  // the warning latches at once
  assign oc_fault_next = oc_fault_set | (oc_fault_reg & ~clear_faults);
  assign oc_warn_next  = oc_warn_s | (oc_warn_reg & ~clear_faults);

  // output current flags
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      oc_fault_reg <= 1'b0;
      oc_warn_reg  <= 1'b0;
    end else begin
      oc_fault_reg <= oc_fault_next;
      oc_warn_reg  <= oc_warn_next;
    end
  end

  // input byte: pin comparators and monitor warnings; a short trip on a
  // pin comparator is kept even if it clears before the host reads
  assign in_ov_fault_next = ov_live_s |
                            (in_ov_fault_reg & ~clear_faults);
  assign in_ov_warn_next  = in_ov_w_s |
                            (in_ov_warn_reg & ~clear_faults);
  assign in_uv_warn_next  = in_uv_w_s |
                            (in_uv_warn_reg & ~clear_faults);
  assign in_uv_fault_next = uv_live_s |
                            (in_uv_fault_reg & ~clear_faults);
  assign in_op_warn_next  = op_w_s |
                            (in_op_warn_reg & ~clear_faults);

  // input flags
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      in_ov_fault_reg <= 1'b0;
      in_ov_warn_reg  <= 1'b0;
      in_uv_warn_reg  <= 1'b0;
      in_uv_fault_reg <= 1'b0;
      in_op_warn_reg  <= 1'b0;
    end else begin
      in_ov_fault_reg <= in_ov_fault_next;
      in_ov_warn_reg  <= in_ov_warn_next;
      in_uv_warn_reg  <= in_uv_warn_next;
      in_uv_fault_reg <= in_uv_fault_next;
      in_op_warn_reg  <= in_op_warn_next;
    end
  end

  // vendor byte latches; the comparator bits stay live and skip these
  assign fet_next   = fet_s | (fet_reg & ~clear_faults);
  assign limit_next = lim_s | (limit_reg & ~clear_faults);
  assign warn2_next = warn2_s | (warn2_reg & ~clear_faults);

  // vendor flags
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fet_reg   <= 1'b0;
      limit_reg <= 1'b0;
      warn2_reg <= 1'b0;
    end else begin
      fet_reg   <= fet_next;
      limit_reg <= limit_next;
      warn2_reg <= warn2_next;
    end
  end

  // gate pulled down this cycle; the reason is sampled only on this edge
  assign gate_off_rise = gate_off_s & ~gate_off_d_reg;

  // reason captured on the gate's falling-off edge; ov beats uv beats oc
  always_comb begin
    cause_next = cause_reg;
    if (clear_faults) begin
      cause_next = pfs_pkg::PFS_CAUSE_NONE;
    end
    if (gate_off_rise) begin
      if (ov_live_s) begin
        cause_next = pfs_pkg::PFS_CAUSE_OV;
      end else if (uv_live_s) begin
        cause_next = pfs_pkg::PFS_CAUSE_UV;
      end else if (oc_tmo_s) begin
        cause_next = pfs_pkg::PFS_CAUSE_OC;
      end
    end
  end

  // shutdown reason, held until a clear or the next shutdown
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cause_reg <= pfs_pkg::PFS_CAUSE_NONE;
    end else begin
      cause_reg <= cause_next;
    end
  end

  // gate history resets low, the pin's running level, so no false edge
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      gate_off_d_reg <= 1'b0;
    end else begin
      gate_off_d_reg <= gate_off_s;
    end
  end

  // byte assembly; reserved positions stay zero
  always_comb begin
    vout_byte = `PFS_STATUS_RESET;
    vout_byte[`PFS_VOUT_OV_BIT] = vout_ov_reg;
    vout_byte[`PFS_VOUT_UV_BIT] = vout_uv_reg;
    iout_byte = `PFS_STATUS_RESET;
    iout_byte[`PFS_OVERCURRENT_TIMEOUT_FAULT_BIT] = oc_fault_reg;
    iout_byte[`PFS_OVERCURRENT_WARNING_BIT]  = oc_warn_reg;
    input_byte = `PFS_STATUS_RESET;
    input_byte[`PFS_IN_OV_FAULT_BIT] = in_ov_fault_reg;
    input_byte[`PFS_IN_OV_WARN_BIT]  = in_ov_warn_reg;
    input_byte[`PFS_IN_UV_WARN_BIT]  = in_uv_warn_reg;
    input_byte[`PFS_IN_UV_FAULT_BIT] = in_uv_fault_reg;
    input_byte[`PFS_IN_OP_WARN_BIT]  = in_op_warn_reg;
    vendor_byte = `PFS_STATUS_RESET;
    vendor_byte[`PFS_VS_FET_BIT]     = fet_reg;
    vendor_byte[`PFS_VS_UV_LIVE_BIT] = uv_live_s;
    vendor_byte[`PFS_VS_OV_LIVE_BIT] = ov_live_s;
    vendor_byte[`PFS_VS_LIMIT_BIT]   = limit_reg;
    vendor_byte[`PFS_VS_CAUSE_HI:`PFS_VS_CAUSE_LO] = cause_reg;
    vendor_byte[`PFS_VS_WARN2_BIT]   = warn2_reg;
  end

  // command decode, one named hit per supported code
  assign hit_vout   = (read_code == `PFS_CODE_VOUT_STATUS);
  assign hit_iout   = (read_code == `PFS_CODE_IOUT_STATUS);
  assign hit_input  = (read_code == `PFS_CODE_INPUT_STATUS);
  assign hit_vendor = (read_code == `PFS_CODE_VENDOR_STATUS);

  // unknown codes answer zero and are flagged; the hits are exclusive,
  // so a plain and-or select needs no priority chain
  assign code_hit       = hit_vout | hit_iout | hit_input | hit_vendor;
  assign read_data_next = ({8{hit_vout}}   & vout_byte)  |
                          ({8{hit_iout}}   & iout_byte)  |
                          ({8{hit_input}}  & input_byte) |
                          ({8{hit_vendor}} & vendor_byte);

  // answer strobes, one cycle after the request and one cycle long
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      read_valid       <= 1'b0;
      read_unsupported <= 1'b0;
    end else begin
      read_valid       <= read_strobe;
      read_unsupported <= read_strobe & ~code_hit;
    end
  end

  // read data holds until the next request, so a slow host may look late
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      read_data <= `PFS_STATUS_RESET;
    end else if (read_strobe) begin
      read_data <= read_data_next;
    end
  end

  // any active bit in a byte raises that byte's summary flag
  assign summary_next = {|vout_byte, |iout_byte, |input_byte,
                         |vendor_byte};

  // registered so the status word sees a glitch-free flag
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_summary <= 4'h0;
    end else begin
      status_summary <= summary_next;
    end
  end
endmodule

// file: test/pfs_host_model.sv
// Purpose: host side that issues single read-byte requests
// Assumes: go is a one-cycle request from the bench
// Notes:   the code bus toggles while idle, so a stale code comes back only every other cycle
`timescale 1ns/1ps
module pfs_host_model (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       go,
  input  wire logic [7:0] code_in,
  output logic            read_strobe,
  output logic      [7:0] read_code
);
  // one strobe per request, idle code inverted every cycle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      read_strobe <= 1'b0;
      read_code   <= 8'h00;
    end else begin
      read_strobe <= go;
      read_code   <= go ? code_in : ~read_code;
    end
  end
endmodule

// file: test/pfs_status_bytes_assertions.sv
// Purpose: port-level checks of the read path
// Assumes: bound to the status byte block
// Notes:   reserved masks follow the byte layouts
`timescale 1ns/1ps
module pfs_status_bytes_assertions (
  input wire logic       core_clk,
  input wire logic       reset_n,
  input wire logic       read_strobe,
  input wire logic [7:0] read_code,
  input wire logic [7:0] read_data,
  input wire logic       read_valid,
  input wire logic       read_unsupported
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // codes with a status byte behind them
  wire known = read_code inside {8'h7a, 8'h7b, 8'h7c, 8'h80};
  AST_VALID_LATENCY: assert property (
    read_strobe |=> read_valid) else $error("read not answered");
  AST_VALID_CAUSE: assert property (
    read_valid |-> $past(read_strobe)) else $error("unrequested answer");
  AST_DATA_HOLD: assert property (
    !read_strobe |=> $stable(read_data)) else $error("data moved idle");
  AST_UNSUPPORTED: assert property (
    read_strobe && !known |=> read_unsupported && read_data == 8'h00)
    else $error("unknown code not refused");
  AST_SUPPORTED: assert property (
    read_strobe && known |=> !read_unsupported) else $error("code refused");
  AST_VOUT_RESERVED: assert property (
    read_strobe && read_code == 8'h7a |=> (read_data & 8'h9f) == 8'h00)
    else $error("vout reserved set");
  AST_IOUT_RESERVED: assert property (
    read_strobe && read_code == 8'h7b |=> (read_data & 8'h5f) == 8'h00)
    else $error("iout reserved set");
  AST_INPUT_RESERVED: assert property (
    read_strobe && read_code == 8'h7c |=> (read_data & 8'h0e) == 8'h00)
    else $error("input reserved set");
  AST_VENDOR_RESERVED: assert property (
    read_strobe && read_code == 8'h80 |=> (read_data & 8'h10) == 8'h00)
    else $error("vendor reserved set");
endmodule
bind pfs_status_bytes pfs_status_bytes_assertions
  i_pfs_status_bytes_assertions (
  .core_clk, .reset_n, .read_strobe, .read_code,
  .read_data, .read_valid, .read_unsupported);

// file: test/testbench.sv
// Purpose: self-checking run over the four status bytes
// Assumes: event inputs settle within five cycles
// Notes:   expected bytes written out from the bit layouts
`timescale 1ns/1ps
`define CHK(n,e,a) begin comparisons++; if ((a) !== (e)) begin \
  err_total++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module testbench;
  logic       core_clk, reset_n, go, clear_faults, read_strobe;
  logic [7:0] code_in, read_code, read_data;
  logic       read_valid, read_unsupported;
  logic [3:0] status_summary;
  logic       output_overvoltage_warning, output_undervoltage_warning;
  logic       overcurrent_timer_expired, gate_shut_down, overcurrent_warning;
  logic       undervoltage_comparator_live, overvoltage_comparator_live;
  logic       input_overvoltage_warning, input_undervoltage_warning;
  logic       input_overpower_warning, pass_transistor_suspect_short;
  logic       current_limiting_active, second_current_over;
  logic       second_current_under, second_warning_polarity_select;
  int         err_total, comparisons;
  logic [9:0] evk [2] = '{10'h040, 10'h020};
  logic [31:0] exk [2] = '{32'h0000_1045, 32'h0000_8026};
  pfs_status_bytes i_pfs_status_bytes (.*);
  pfs_host_model   i_pfs_host_model (.*);
  // free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic tally_and_finish;
    if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic settle;
    repeat (5) @(posedge core_clk);
  endtask
  task automatic ev(input logic [9:0] v);
    {output_overvoltage_warning, output_undervoltage_warning,
     overcurrent_warning, undervoltage_comparator_live,
     overvoltage_comparator_live, input_overvoltage_warning,
     input_undervoltage_warning, input_overpower_warning,
     pass_transistor_suspect_short, current_limiting_active} <= v;
  endtask
  // one read-byte through the host, answer bounded to eight cycles
  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    int   i;
    logic u;
    u = !(c inside {8'h7a, 8'h7b, 8'h7c, 8'h80});
    @(posedge core_clk);
    go      <= 1'b1;
    code_in <= c;
    @(posedge core_clk);
    go <= 1'b0;
    for (i = 0; i < 8 && read_valid !== 1'b1; i++) @(negedge core_clk);
    if (i == 8) begin
      err_total++;
      tally_and_finish;
    end
    `CHK("read_data", e, read_data)
    `CHK("read_unsupported", u, read_unsupported)
    // return on a rising edge so the next stimulus lands on one
    @(posedge core_clk);
  endtask
  task automatic rd4(input logic [31:0] e);
    rd(8'h7a, e[31:24]);
    rd(8'h7b, e[23:16]);
    rd(8'h7c, e[15:8]);
    rd(8'h80, e[7:0]);
  endtask
  task automatic clr;
    @(posedge core_clk);
    clear_faults <= 1'b1;
    @(posedge core_clk);
    clear_faults <= 1'b0;
    settle;
  endtask
  // main sequence: reset, latch, live, cause, clear
  initial begin
    reset_n = 1'b0;
    go = 1'b0;
    code_in = 8'h00;
    clear_faults = 1'b0;
    ev(10'h000);
    overcurrent_timer_expired = 1'b0;
    gate_shut_down = 1'b0;
    second_current_over = 1'b0;
    second_current_under = 1'b0;
    second_warning_polarity_select = 1'b0;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    rd4(32'h0);
    rd(8'h79, 8'h00);
    ev(10'h3ff);
    overcurrent_timer_expired <= 1'b1;
    second_current_over <= 1'b1;
    settle;
    `CHK("status_summary", 4'hf, status_summary)
    rd4(32'h6020_f1e9);
    ev(10'h000);
    settle;
    rd4(32'h6020_f189);
    gate_shut_down <= 1'b1;
    settle;
    rd4(32'h60a0_f18b);
    gate_shut_down <= 1'b0;
    overcurrent_timer_expired <= 1'b0;
    second_current_over <= 1'b0;
    settle;
    clr;
    rd4(32'h0);
    `CHK("status_summary", 4'h0, status_summary)
    second_warning_polarity_select <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      ev(evk[k]);
      second_current_under <= (k == 0);
      settle;
      gate_shut_down <= 1'b1;
      settle;
      rd4(exk[k]);
      ev(10'h000);
      gate_shut_down <= 1'b0;
      second_current_under <= 1'b0;
      settle;
      clr;
    end
    // latch one flag, then a mid-run reset must wipe it
    ev(10'h200);
    settle;
    ev(10'h000);
    settle;
    rd(8'h7a, 8'h40);
    `CHK("status_summary", 4'h8, status_summary)
    reset_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(8'h7a, 8'h00);
    `CHK("status_summary", 4'h0, status_summary)
    tally_and_finish;
  end
endmodule
